// file: bench/bus_host_model.sv
`default_nettype none
module bus_host_model (
	input wire logic i_clk_sys,
	output logic o_cyc_valid,
	output logic [15:0] o_bus_addr,
	output logic [7:0] o_bus_data,
	output logic o_bus_rw,
	output logic o_bus_lir,
	output logic [5:0] o_probes,
	output logic o_sel_hit
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		{o_cyc_valid, o_bus_addr, o_bus_data, o_bus_rw} = '0;
		{o_bus_lir, o_probes, o_sel_hit} = '0;
	end
	// One processor cycle; selective capture keeps instruction starts
	task automatic cyc(input logic [15:0] a, input logic [7:0] d,
		input logic rw, lir, input logic [5:0] p);
		@(negedge i_clk_sys);
		{o_bus_addr, o_bus_data, o_bus_rw} = {a, d, rw};
		{o_bus_lir, o_sel_hit, o_probes} = {lir, lir, p};
		o_cyc_valid = 1'b1;
		@(negedge i_clk_sys);
		o_cyc_valid = 1'b0;
		// Released bus shows junk, never the last value
		{o_bus_addr, o_bus_data, o_probes, o_bus_rw} = ~{a, d, p, rw};
		{o_bus_lir, o_sel_hit} = ~{lir, lir};
	endtask : cyc
endmodule : bus_host_model
`default_nettype wire

// file: bench/bus_trace_props.sv
`default_nettype none
module bus_trace_props (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_cyc_valid,
	input wire logic [15:0] i_bus_addr,
	input wire logic i_bus_rw,
	input wire logic i_bus_lir,
	input wire logic i_arm,
	input wire logic [1:0] i_mode,
	input wire logic i_stop,
	input wire logic i_break_ack,
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd_op,
	input wire logic [13:0] i_cmd_count,
	input wire logic signed [14:0] i_cmd_offset,
	input wire logic o_break_req,
	input wire logic [1:0] o_fault_kind,
	input wire logic o_capturing,
	input wire logic o_busy,
	input wire logic o_refused,
	input wire logic signed [14:0] o_offset,
	input wire logic [13:0] o_count
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Bus cycle seen once storing has begun
	logic live;
	// Command that the block must take
	logic take;
	assign live = o_capturing && i_cyc_valid && o_count != 14'h0;
	assign take = i_cmd_valid && !o_busy && !i_arm;
	a_write_fault: assert property (live && i_mode == 2'h2 && !i_bus_rw
		&& i_bus_addr >= 16'hC000 |=> o_break_req && o_fault_kind == 2'h1)
		else $error("write fault missed");
	a_fetch_fault: assert property (live && i_mode == 2'h2 && i_bus_lir
		&& i_bus_addr < 16'hC000 |=> o_break_req && o_fault_kind == 2'h2)
		else $error("fetch fault missed");
	a_break_hold: assert property (o_break_req && !i_break_ack
		&& !i_arm |=> o_break_req) else $error("break dropped");
	a_ack_clears: assert property (i_break_ack |=> !o_break_req)
		else $error("break not cleared");
	a_fault_stop: assert property ($rose(o_break_req) |->
		!o_capturing && o_offset == 15'sh0) else $error("trigger wrong");
	a_count_step: assert property (live && i_mode == 2'h0 && !i_stop
		&& o_count < 14'h2000 |=> o_count == $past(o_count) + 14'h1)
		else $error("record not counted");
	a_arm_start: assert property (i_arm && !o_busy |=>
		o_capturing && o_busy) else $error("arm ignored");
	a_zero_nth: assert property (take && i_cmd_op != 2'h0 &&
		i_cmd_op != 2'h3 && i_cmd_count == 14'h0 |-> ##[1:2] o_refused)
		else $error("nth zero taken");
	a_pos_range: assert property (take && i_cmd_op == 2'h0 &&
		(i_cmd_offset > 15'sh2000 || i_cmd_offset < -15'sh2000)
		|-> ##[1:2] o_refused) else $error("offset range taken");
endmodule : bus_trace_props
bind bus_trace_unit bus_trace_props u_props (.*);
`default_nettype wire

// file: bench/test_bus_trace_fault_capture.sv
`default_nettype none
module test_bus_trace_fault_capture import trace_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk_sys, i_nrst, i_cyc_valid, i_bus_rw, i_bus_lir, i_sel_hit;
	logic i_arm, i_stop, i_break_ack, i_cmd_valid, i_cmd_back, i_pat_instr;
	logic [15:0] i_bus_addr;
	logic [7:0] i_bus_data;
	logic [5:0] i_user_probe_inputs;
	logic [1:0] i_mode, i_cmd_op, o_fault_kind;
	logic [13:0] i_cmd_count, o_cycles, o_count;
	logic signed [14:0] i_cmd_offset, o_offset;
	logic [31:0] i_pat_value, i_pat_care, o_rec, seed, recs[$], rq[$];
	logic [2:0] i_pat_fields;
	logic o_break_req, o_capturing, o_busy, o_done, o_found, o_refused;
	logic o_rec_valid, ans;
	logic [16:0] st, dq[$];
	int n_errors, compares, i;
	bus_trace_unit dut (.*);
	bus_host_model host (.i_clk_sys(i_clk_sys), .o_cyc_valid(i_cyc_valid),
		.o_bus_addr(i_bus_addr), .o_bus_data(i_bus_data),
		.o_bus_rw(i_bus_rw), .o_bus_lir(i_bus_lir),
		.o_probes(i_user_probe_inputs), .o_sel_hit(i_sel_hit));
	// Command answer and its status word
	assign ans = o_done | o_refused;
	assign st = {o_refused, o_found, o_offset};
	always #12.5 i_clk_sys = ~i_clk_sys;
	task close_out;
		if (n_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	task chk_rec(input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk_rec
	task chk_st(input logic [16:0] e, g);
		chk_rec({15'h0, e}, {15'h0, g});
	endtask : chk_st
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Bounded wait for a level; running out ends the run
	task automatic til(ref logic s, input logic v);
		int k;
		for (k = 0; k < 300 && s !== v; k++) @(negedge i_clk_sys);
		if (s !== v) begin
			n_errors++;
			close_out();
		end
	endtask : til
	task automatic pls(ref logic s);
		@(negedge i_clk_sys);
		s = 1'b1;
		@(negedge i_clk_sys);
		s = 1'b0;
	endtask : pls
	// Bus cycle with random data and probes; note it if it gets stored
	task automatic bc(input logic [15:0] a, input logic rw, lir, sv);
		seed = xs(seed);
		host.cyc(a, seed[7:0], rw, lir, seed[13:8]);
		if (sv) recs.push_back({a, seed[7:0], seed[13:8], lir, rw});
	endtask : bc
	task automatic cmd(input logic [1:0] op, input logic b,
		input logic [13:0] n, input logic signed [14:0] of,
		input logic [31:0] v, c, input logic [2:0] f, input logic ins,
		input logic [16:0] e);
		dq.push_back(e);
		@(negedge i_clk_sys);
		{i_cmd_op, i_cmd_back, i_cmd_count, i_cmd_offset} = {op, b, n, of};
		{i_pat_value, i_pat_care, i_pat_fields, i_pat_instr} = {v, c, f, ins};
		i_cmd_valid = 1'b1;
		@(negedge i_clk_sys);
		i_cmd_valid = 1'b0;
		til(ans, 1'b1);
	endtask : cmd
	// Result watcher: oldest note against each answer
	always @(posedge i_clk_sys) begin
		if (o_rec_valid) chk_rec(rq.pop_front(), o_rec);
		// A timing answer carries its walked-record count first
		if (ans && i_cmd_op == CMD_TIME)
			chk_st(dq.pop_front(), {3'h0, o_cycles});
		if (ans) chk_st(dq.pop_front(), st);
		if ($rose(o_break_req))
			chk_st(dq.pop_front(), {o_fault_kind, o_offset});
	end
	initial begin
		{i_clk_sys, i_nrst, i_arm, i_stop, i_break_ack, i_cmd_valid} = '0;
		{i_cmd_back, i_pat_instr, i_mode, i_cmd_op, i_cmd_count} = '0;
		{i_cmd_offset, i_pat_value, i_pat_care, i_pat_fields} = '0;
		{n_errors, compares, seed} = {32'h0, 32'h0, 32'd33250};
		repeat (10) @(negedge i_clk_sys);
		i_nrst = 1'b1;
		// Full capture; the low fetch precedes user code
		i_mode = MODE_FULL;
		pls(i_arm);
		bc(16'h0100, 1'b1, 1'b1, 1'b0);
		bc(16'hF800, 1'b1, 1'b1, 1'b1);
		bc(16'hF801, 1'b1, 1'b0, 1'b1);
		bc(16'hF802, 1'b1, 1'b1, 1'b1);
		bc(16'h1000, 1'b0, 1'b0, 1'b1);
		bc(16'hF804, 1'b1, 1'b1, 1'b1);
		bc(16'hF805, 1'b1, 1'b0, 1'b1);
		bc(16'hF800, 1'b1, 1'b1, 1'b1);
		pls(i_stop);
		til(o_busy, 1'b0);
		for (i = 0; i < 4; i++) rq.push_back(recs[i]);
		cmd(CMD_READ, '0, 14'h1, '0, '0, '0, '0, '0, 17'h08002);
		cmd(CMD_READ, '0, 14'h1, '0, '0, '0, '0, '0, 17'h08004);
		cmd(CMD_SETPOS, '0, '0, '0, '0, '0, '0, '0, 17'h08000);
		cmd(CMD_FIND, '0, 14'h1, '0, 32'hF8000000, 32'hFFFF0000,
			3'h6, '1, 17'h08006);
		cmd(CMD_FIND, '1, 14'h1, '0, 32'hF8020000, 32'hFFFF0000,
			3'h4, '1, 17'h08002);
		cmd(CMD_FIND, '0, 14'h2, '0, 32'h3, 32'h3, 3'h1, '0,
			17'h08006);
		cmd(CMD_FIND, '1, 14'h1, '0, 32'hF8010000, 32'hFFFF0000,
			3'h4, '1, 17'h00006);
		cmd(CMD_FIND, '0, '0, '0, '0, '0, 3'h4, '0, 17'h10006);
		cmd(CMD_SETPOS, '0, '0, 15'sh2001, '0, '0, '0, '0, 17'h10006);
		cmd(CMD_SETPOS, '0, '0, '0, '0, '0, '0, '0, 17'h08000);
		// Records walked from the placed event to the match, then status
		dq.push_back(17'h00003);
		cmd(CMD_TIME, '0, 14'h1, '0, 32'h10000000, 32'hFFFF0000,
			3'h4, '0, 17'h08002);
		// Selective capture refuses instruction readout
		i_mode = MODE_SEL;
		pls(i_arm);
		bc(16'hF800, 1'b1, 1'b1, 1'b0);
		bc(16'hF801, 1'b1, 1'b0, 1'b0);
		pls(i_stop);
		til(o_busy, 1'b0);
		cmd(CMD_READ, '0, 14'h1, '0, '0, '0, '0, '0, 17'h10000);
		// Write fault, then fetch fault
		i_mode = MODE_FAULT;
		dq.push_back({2'h1, 15'h0});
		pls(i_arm);
		bc(16'hF800, 1'b1, 1'b1, 1'b0);
		bc(16'hC010, 1'b0, 1'b0, 1'b0);
		til(o_break_req, 1'b1);
		pls(i_break_ack);
		dq.push_back({2'h2, 15'h0});
		pls(i_arm);
		bc(16'hF800, 1'b1, 1'b1, 1'b0);
		bc(16'h0100, 1'b1, 1'b1, 1'b0);
		til(o_break_req, 1'b1);
		pls(i_break_ack);
		close_out();
	end
endmodule : test_bus_trace_fault_capture
`default_nettype wire

// file: common/trace_cfg.svh
`ifndef TRACE_CFG_SVH
`define TRACE_CFG_SVH
// Record index width and depth of the capture store
`define TRC_IDX_W 13
`define TRC_DEPTH 14'h2000
// Base of the top 16K region of the monitored address space
`define TRC_TOP_BASE 16'hC000
// Record layout: address, data, auxiliary byte
`define TRC_ADDR_LSB 16
`define TRC_DATA_LSB 8
`define TRC_PROBE_LSB 2
`define TRC_MARK_BIT 1
`define TRC_RW_BIT 0
// Largest offset magnitude accepted for a position set
`define TRC_OFS_MAX 15'sh2000
`endif

// file: common/trace_pkg.sv
`default_nettype none
package trace_pkg;
	// Controller states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CAPT  = 5'h02,
		ST_SCAN  = 5'h04,
		ST_ALIGN = 5'h08,
		ST_READ  = 5'h10
	} state_e;
	// Capture modes
	typedef enum logic [1:0] {
		MODE_FULL  = 2'h0,
		MODE_SEL   = 2'h1,
		MODE_FAULT = 2'h2
	} mode_e;
	// Post-capture commands
	typedef enum logic [1:0] {
		CMD_SETPOS = 2'h0,
		CMD_FIND   = 2'h1,
		CMD_TIME   = 2'h2,
		CMD_READ   = 2'h3
	} cmd_e;
	// Fault kinds
	typedef enum logic [1:0] {
		FLT_NONE  = 2'h0,
		FLT_WRITE = 2'h1,
		FLT_FETCH = 2'h2
	} fault_e;
endpackage : trace_pkg
`default_nettype wire

// file: rtl/bus_trace_unit.sv
`default_nettype none
`include "trace_cfg.svh"
module bus_trace_unit import trace_pkg::*; #(
	parameter int IDX_W = `TRC_IDX_W
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_cyc_valid,
	input wire logic [15:0] i_bus_addr,
	input wire logic [7:0] i_bus_data,
	input wire logic i_bus_rw,
	input wire logic i_bus_lir,
	input wire logic [5:0] i_user_probe_inputs,
	input wire logic i_sel_hit,
	input wire logic i_arm,
	input wire logic [1:0] i_mode,
	input wire logic i_stop,
	input wire logic i_break_ack,
	input wire logic i_cmd_valid,
	input wire logic [1:0] i_cmd_op,
	input wire logic i_cmd_back,
	input wire logic [13:0] i_cmd_count,
	input wire logic signed [14:0] i_cmd_offset,
	input wire logic [31:0] i_pat_value,
	input wire logic [31:0] i_pat_care,
	input wire logic [2:0] i_pat_fields,
	input wire logic i_pat_instr,
	output logic o_break_req,
	output logic [1:0] o_fault_kind,
	output logic o_capturing,
	output logic o_busy,
	output logic o_done,
	output logic o_found,
	output logic o_refused,
	output logic signed [14:0] o_offset,
	output logic [13:0] o_cycles,
	output logic [13:0] o_count,
	output logic [31:0] o_rec,
	output logic o_rec_valid
);
	// Whole controller state
	typedef struct packed {
		state_e st;            // Controller state
		mode_e mode;           // Mode of the last capture
		logic started;         // User code reached top region
		logic [IDX_W-1:0] wr;  // Next write index
		logic [13:0] cnt;      // Records held
		logic [IDX_W-1:0] lmark; // Last stored instruction start
		logic [IDX_W-1:0] trig;  // Trigger record
		logic [IDX_W-1:0] pos;   // Current position
		logic [IDX_W-1:0] save;  // Position before a search
		logic [13:0] nleft;    // Matches still to pass
		logic back;            // Search direction backward
		logic timing;          // Search belongs to a cycle count
		logic first;           // First record of a readout
		logic [13:0] steps;    // Cycles walked in a count
		logic brk;             // Break request to the processor
		fault_e fkind;         // Kind of the last fault
		logic busy;            // Controller not idle
		logic capt;            // Capture running
		logic done;            // Command finished pulse
		logic found;           // Command succeeded
		logic refused;         // Command refused pulse
		logic signed [14:0] ofs; // Position relative to trigger
		logic [31:0] rec;      // Record output
		logic rec_valid;       // Record output strobe
	} trace_s;

	localparam logic [13:0] DEPTH = `TRC_DEPTH;

	trace_s q; // Registered state
	trace_s d; // Next state

	logic [31:0] mem [0:(1<<IDX_W)-1]; // Capture store
	logic mem_we;                      // Store write strobe
	logic [IDX_W-1:0] mem_wa;          // Store write index
	logic [31:0] mem_wd;               // Store write record
	logic [31:0] cur;                  // Record at current position
	logic [31:0] care;                 // Effective compare mask
	logic hit;                         // Current record matches
	logic cur_mark;                    // Current record is instruction start
	logic [IDX_W-1:0] oldest;          // Oldest record index
	logic [IDX_W-1:0] rel;             // Current position from oldest
	logic can_fwd;                     // A later record exists
	logic can_bwd;                     // An earlier record exists
	logic in_top;                      // Bus address in top 16K
	logic mark;                        // Mark bit for this cycle
	logic [7:0] aux;                   // Auxiliary byte for this cycle
	logic signed [14:0] tgt;           // Position target from oldest

	// Per-field enables narrow the compare mask
	always_comb begin
		care = i_pat_care;
		if (!i_pat_fields[2]) care[31:16] = 16'h0000;
		if (!i_pat_fields[1]) care[15:8] = 8'h00;
		if (!i_pat_fields[0]) care[7:0] = 8'h00;
	end

	// Current record and its relation to the stored span
	assign cur = mem[q.pos];
	assign cur_mark = cur[`TRC_MARK_BIT];
	assign hit = (((cur ^ i_pat_value) & care) == 32'h0000_0000) &&
		(!i_pat_instr || cur_mark);
	assign oldest = (q.cnt == DEPTH) ? q.wr : '0;
	assign rel = q.pos - oldest;
	assign can_fwd = ({1'b0, rel} + 14'h0001) < q.cnt;
	assign can_bwd = rel != '0;
	assign in_top = i_bus_addr >= `TRC_TOP_BASE;

	// Auxiliary byte: probes high, mark, read/write low
	assign mark = (q.mode == MODE_SEL) ? 1'b1 : i_bus_lir;
	assign aux = {i_user_probe_inputs, mark, i_bus_rw};

	// Main controller
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.refused = 1'b0;
		d.rec_valid = 1'b0;
		mem_we = 1'b0;
		mem_wa = q.wr;
		// Probes taken in the same cycle as the data bus value
		mem_wd = {i_bus_addr, i_bus_data, aux};
		tgt = $signed({2'b00, q.trig - oldest}) + i_cmd_offset;
		if (i_break_ack) begin
			d.brk = 1'b0; // Monitor has taken control
		end
		case (q.st)
			// Waiting for arm or a command
			ST_IDLE: begin
				if (i_arm) begin
					d.st = ST_CAPT;
					d.mode = mode_e'(i_mode);
					d.started = 1'b0;
					d.wr = '0;
					d.cnt = 14'h0000;
					d.lmark = '0;
					d.trig = '0;
					d.pos = '0;
					d.brk = 1'b0;
					d.fkind = FLT_NONE;
				end else if (i_cmd_valid) begin
					d.save = q.pos;
					d.back = i_cmd_back;
					d.nleft = i_cmd_count;
					d.steps = 14'h0000;
					d.first = 1'b1;
					d.found = 1'b0;
					if (q.cnt == 14'h0000) begin
						d.refused = 1'b1; // Nothing captured
					end else begin
						case (cmd_e'(i_cmd_op))
							CMD_SETPOS: begin
								if (i_cmd_offset > `TRC_OFS_MAX ||
									i_cmd_offset < -`TRC_OFS_MAX ||
									tgt < 15'sh0000 ||
									tgt >= $signed({1'b0, q.cnt})) begin
									d.refused = 1'b1;
								end else begin
									d.pos = oldest + tgt[IDX_W-1:0];
									d.done = 1'b1;
									d.found = 1'b1;
								end
							end
							CMD_FIND, CMD_TIME: begin
								if (i_cmd_count == 14'h0000) begin
									d.refused = 1'b1;
								end else if (i_cmd_back ? can_bwd : can_fwd) begin
									// Search starts next to the current position
									d.pos = i_cmd_back ? q.pos - 1'b1 : q.pos + 1'b1;
									d.steps = 14'h0001;
									d.timing = (i_cmd_op == CMD_TIME);
									d.st = ST_SCAN;
								end else begin
									d.done = 1'b1; // Already at the end
								end
							end
							default: begin
								if (q.mode == MODE_SEL) begin
									d.refused = 1'b1;
								end else begin
									d.st = ST_READ;
								end
							end
						endcase
					end
				end
			end
			// Watching bus cycles; only a fault in fault mode drives a break request back
			ST_CAPT: begin
				if (i_stop) begin
					d.st = ST_IDLE;
					d.pos = q.trig;
				end else if (i_cyc_valid) begin
					if (!q.started && i_bus_lir && in_top) begin
						d.started = 1'b1;
					end
					if (q.started && q.mode == MODE_FAULT &&
						i_bus_lir && !in_top) begin
						// Fetch not stored; trigger is last good instruction
						d.fkind = FLT_FETCH;
						d.brk = 1'b1;
						d.trig = q.lmark;
						d.pos = q.lmark;
						d.st = ST_IDLE;
					end else if ((q.started || (i_bus_lir && in_top)) &&
						(q.mode != MODE_SEL || i_sel_hit)) begin
						mem_we = 1'b1;
						d.wr = q.wr + 1'b1;
						if (q.cnt != DEPTH) d.cnt = q.cnt + 14'h0001;
						if (mark) d.lmark = q.wr;
						if (q.mode == MODE_FAULT && !i_bus_rw && in_top) begin
							// Write is stored; trigger is its instruction
							d.fkind = FLT_WRITE;
							d.brk = 1'b1;
							d.trig = mark ? q.wr : q.lmark;
							d.pos = d.trig;
							d.st = ST_IDLE;
						end else if (q.mode != MODE_FAULT &&
							q.cnt == DEPTH - 14'h0001) begin
							d.st = ST_IDLE; // Store full
							d.pos = q.trig;
						end
					end
				end
			end
			// Searching one record per cycle
			ST_SCAN: begin
				if (hit && q.nleft == 14'h0001) begin
					d.found = 1'b1;
					if (q.timing && !cur_mark) begin
						d.st = ST_ALIGN;
					end else begin
						d.st = ST_IDLE;
						d.done = 1'b1;
					end
				end else begin
					if (hit) d.nleft = q.nleft - 14'h0001;
					if (q.back ? can_bwd : can_fwd) begin
						d.pos = q.back ? q.pos - 1'b1 : q.pos + 1'b1;
						d.steps = q.steps + 14'h0001;
					end else begin
						// Ran off the store: position is restored
						d.pos = q.save;
						d.st = ST_IDLE;
						d.done = 1'b1;
					end
				end
			end
			// Back to the start of the instruction holding the event
			ST_ALIGN: begin
				if (cur_mark || !can_bwd) begin
					d.st = ST_IDLE;
					d.done = 1'b1;
				end else begin
					d.pos = q.pos - 1'b1;
				end
			end
			// Streaming out one instruction's records
			ST_READ: begin
				if (!q.first && cur_mark) begin
					d.st = ST_IDLE; // Resting on next instruction
					d.done = 1'b1;
					d.found = 1'b1;
				end else begin
					d.rec = cur;
					d.rec_valid = 1'b1;
					d.first = 1'b0;
					if (can_fwd) begin
						d.pos = q.pos + 1'b1;
					end else begin
						d.st = ST_IDLE; // End of store
						d.done = 1'b1;
						d.found = 1'b1;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		d.busy = (d.st != ST_IDLE);
		d.capt = (d.st == ST_CAPT);
		d.ofs = $signed({2'b00, d.pos - ((d.cnt == DEPTH) ? d.wr : '0)}) -
			$signed({2'b00, d.trig - ((d.cnt == DEPTH) ? d.wr : '0)});
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.mode <= MODE_FULL;
			q.fkind <= FLT_NONE;
		end else begin
			q <= d;
		end
	end

	// Capture store write port
	always_ff @(posedge i_clk_sys) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// Outputs straight from the state register
	assign o_break_req = q.brk;
	assign o_fault_kind = q.fkind;
	assign o_capturing = q.capt;
	assign o_busy = q.busy;
	assign o_done = q.done;
	assign o_found = q.found;
	assign o_refused = q.refused;
	assign o_offset = q.ofs;
	assign o_cycles = q.steps;
	assign o_count = q.cnt;
	assign o_rec = q.rec;
	assign o_rec_valid = q.rec_valid;
endmodule : bus_trace_unit
`default_nettype wire
